// ---- src/lcdbp_defs.vh ----
// Constants for the LCD RAM bank and pointer command block.
// Assumes a 20 MHz pclk and a 32-bit APB slave port with byte addresses.
`ifndef LCDBP_DEFS_VH
`define LCDBP_DEFS_VH

// Clock and timing
`define LCDBP_PCLK_HZ      20000000
`define LCDBP_FRAME_DIV    8'd144
`define LCDBP_FRAME_LAST   8'd143
`define LCDBP_COLS_LAST    7'd101

// Register byte offsets
`define LCDBP_OFS_CMD      8'h00
`define LCDBP_OFS_CTRL     8'h04
`define LCDBP_OFS_STATUS   8'h08
`define LCDBP_OFS_RDADDR   8'h0C
`define LCDBP_OFS_RDDATA   8'h10

// CMD register fields
`define LCDBP_CMD_RS_LSB   8
`define LCDBP_CMD_RS_MSB   9

// CTRL register fields
`define LCDBP_CTRL_OSC     0
`define LCDBP_CTRL_COE     1

// STATUS register fields
`define LCDBP_ST_PTR_LSB   0
`define LCDBP_ST_WB_LSB    8
`define LCDBP_ST_SB_LSB    10
`define LCDBP_ST_MUX_LSB   12
`define LCDBP_ST_FF_LSB    15
`define LCDBP_ST_DISP      20
`define LCDBP_ST_SEQ_LSB   21

// Register-select values
`define LCDBP_RS_CMD       2'b00
`define LCDBP_RS_DATA      2'b01

// Command prefixes
`define LCDBP_MUX_PFX      5'b00000
`define LCDBP_DISP_PFX     7'b0011100
`define LCDBP_FF_PFX       3'b111
`define LCDBP_WBANK_PFX    6'b000010
`define LCDBP_SBANK_PFX    6'b000100
`define LCDBP_PTR_INIT     8'hA0
`define LCDBP_PTR_UP_PFX   5'b10000
`define LCDBP_PTR_LO_PFX   4'b1001

// Multiplex codes
`define LCDBP_MUX_1_4      3'b101
`define LCDBP_MUX_1_2      3'b110
`define LCDBP_MUX_STATIC   3'b111

// Reset values
`define LCDBP_RST_MUX      3'b101
`define LCDBP_RST_FF       5'h07
`define LCDBP_RST_BANK     2'h0
`define LCDBP_RST_PTR      7'h00
`define LCDBP_RST_CTRL     2'h0

`endif

// ---- src/lcdbp_ram.v ----
// Display RAM: 4 rows of 128 byte columns, one write port, two read ports.
// Assumes one clock; read data are registered, so they lag the address by one edge.
`timescale 1ns/1ns
module lcdbp_ram (
   // Clock
   input  wire       clk,
   // Write port
   input  wire       wr_en,
   input  wire [8:0] wr_addr,
   input  wire [7:0] wr_data,
   // Read port A (software)
   input  wire [8:0] rd_a_addr,
   output reg  [7:0] rd_a_data,
   // Read port B (display scan)
   input  wire [8:0] rd_b_addr,
   output reg  [7:0] rd_b_data
);
   reg [7:0] mem [0:511];   // No reset: contents are undefined after power-on

   // Write and registered reads
   always @(posedge clk)
   begin
      if (wr_en)
         mem[wr_addr] <= wr_data;
      rd_a_data <= mem[rd_a_addr];
      rd_b_data <= mem[rd_b_addr];
   end
endmodule // lcdbp_ram

// ---- src/lcdbp_ctrl.v ----
// Command interpreter for a segment LCD display RAM path, reached over APB.
// Assumes pclk at 20 MHz and an APB master that holds each request until pready.
`timescale 1ns/1ns
`include "lcdbp_defs.vh"
module lcdbp_ctrl (
   // Clock and reset
   input  wire        pclk,
   input  wire        presetn,
   // APB slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output wire        pready,
   output wire        pslverr,
   // Clock output pin (driven only when enabled)
   output wire        clk_out,
   output wire        clk_out_oe,
   // LCD drive
   output reg  [3:0]  backplane_out,
   output reg  [7:0]  segment_out,
   output reg         frame_sync,
   output wire        display_on
);
   // Pointer load sequence states
   localparam [2:0] PS_IDLE = 3'b001;
   localparam [2:0] PS_INIT = 3'b010;
   localparam [2:0] PS_UPR  = 3'b100;

   // Internal clock frequency per frame code
   function integer fclk_hz;
      input integer c;
      begin
         case (c)
            0: fclk_hz = 6472;    1: fclk_hz = 7200;    2: fclk_hz = 7945;    3: fclk_hz = 8662;
            4: fclk_hz = 9366;    5: fclk_hz = 10105;   6: fclk_hz = 10766;   7: fclk_hz = 11520;
            8: fclk_hz = 12255;   9: fclk_hz = 12944;   10: fclk_hz = 13714;  11: fclk_hz = 14400;
            12: fclk_hz = 15781;  13: fclk_hz = 17194;  14: fclk_hz = 18581;  15: fclk_hz = 20211;
            16: fclk_hz = 21736;  17: fclk_hz = 23040;  18: fclk_hz = 24511;  19: fclk_hz = 26182;
            20: fclk_hz = 27429;  21: fclk_hz = 28800;  22: fclk_hz = 30316;  23: fclk_hz = 32000;
            24: fclk_hz = 32914;  25: fclk_hz = 34909;  26: fclk_hz = 36000;  27: fclk_hz = 37161;
            28: fclk_hz = 38400;  29: fclk_hz = 39724;  30: fclk_hz = 41143;  default: fclk_hz = 42667;
         endcase
      end
   endfunction

   // Typical high-time percentage per frame code
   function integer duty_pct;
      input integer c;
      begin
         case (c)
            0: duty_pct = 29;   1: duty_pct = 20;   2: duty_pct = 12;   3: duty_pct = 4;
            4: duty_pct = 48;   5: duty_pct = 44;   6: duty_pct = 41;   7: duty_pct = 36;
            8: duty_pct = 32;   9: duty_pct = 29;   10: duty_pct = 24;  11: duty_pct = 20;
            12: duty_pct = 13;  13: duty_pct = 5;   14: duty_pct = 49;  15: duty_pct = 44;
            16: duty_pct = 40;  17: duty_pct = 36;  18: duty_pct = 32;  19: duty_pct = 28;
            20: duty_pct = 24;  21: duty_pct = 20;  22: duty_pct = 16;  23: duty_pct = 12;
            24: duty_pct = 9;   25: duty_pct = 4;   26: duty_pct = 50;  27: duty_pct = 49;
            28: duty_pct = 47;  29: duty_pct = 45;  30: duty_pct = 43;  default: duty_pct = 41;
         endcase
      end
   endfunction

   // RAM row for a bank code; phase picks the row within a multi-row bank
   function [1:0] row_of;
      input [1:0] code;
      input [2:0] mux;
      input [1:0] phase;
      begin
         case (mux)
            `LCDBP_MUX_STATIC: row_of = code;
            `LCDBP_MUX_1_2:    row_of = {code[1], phase[0]};
            default:           row_of = phase;             // Bank codes ignored
         endcase
      end
   endfunction

   // State registers
   reg  [6:0]  ptr_reg;         // Data pointer
   reg  [2:0]  ptr_upper_reg;   // Upper pointer bits awaiting the lower command
   reg  [2:0]  seq_reg;         // Pointer load sequence
   reg  [1:0]  wbank_reg;       // write_bank_code
   reg  [1:0]  sbank_reg;       // shown_bank_code
   reg  [2:0]  mux_reg;         // Multiplex mode
   reg  [4:0]  ff_reg;          // frame_rate_code
   reg         disp_reg;        // Display enable
   reg  [1:0]  ctrl_reg;        // Oscillator enable and clock output enable
   reg  [8:0]  rdaddr_reg;      // Software read address {row, column}
   reg         rd_wait_reg;     // Read data captured, answer this cycle
   // Next values from the command decoder
   reg  [6:0]  ptr_next;
   reg  [2:0]  ptr_upper_next;
   reg  [2:0]  seq_next;
   reg  [1:0]  wbank_next;
   reg  [1:0]  sbank_next;
   reg  [2:0]  mux_next;
   reg  [4:0]  ff_next;
   reg         disp_next;
   reg         ram_we;
   reg  [31:0] rd_mux;
   // Internal clock and scan
   reg  [11:0] cnt_reg;         // pclk cycles within one internal clock period
   reg         iclk_reg;        // Internal clock level
   reg  [7:0]  fr_cnt_reg;      // Internal clock periods within one frame
   reg  [1:0]  phase_reg;       // Active backplane
   reg  [6:0]  col_reg;         // Scan column
   wire [7:0]  ram_a_q;
   wire [7:0]  ram_b_q;
   wire [383:0] per_tab;        // 32 periods of 12 bits
   wire [383:0] hi_tab;         // 32 high times of 12 bits

   // APB decode
   wire        access   = psel & penable;
   wire        addr_ok  = (paddr == `LCDBP_OFS_CMD) | (paddr == `LCDBP_OFS_CTRL) |
                          (paddr == `LCDBP_OFS_STATUS) | (paddr == `LCDBP_OFS_RDADDR) |
                          (paddr == `LCDBP_OFS_RDDATA);
   wire        wr_fire  = access & pwrite & addr_ok;
   wire        cmd_fire = wr_fire & (paddr == `LCDBP_OFS_CMD);
   wire [1:0]  register_select = pwdata[`LCDBP_CMD_RS_MSB:`LCDBP_CMD_RS_LSB];
   wire [7:0]  display_byte    = pwdata[7:0];
   wire        osc_en   = ctrl_reg[`LCDBP_CTRL_OSC];
   wire        coe      = ctrl_reg[`LCDBP_CTRL_COE];

   // Writes answer at once; reads take one wait cycle so the RAM register settles
   assign pready  = pwrite | rd_wait_reg;
   assign pslverr = access & pready & ~addr_ok;

   // Period and high time per code, worked out at elaboration
   genvar gi;
   generate
      for (gi = 0; gi < 32; gi = gi + 1)
      begin : g_tab
         localparam integer PER = `LCDBP_PCLK_HZ / fclk_hz(gi);
         localparam integer HI  = (PER * duty_pct(gi)) / 100;
         assign per_tab[gi*12 +: 12] = PER[11:0];
         assign hi_tab[gi*12 +: 12]  = HI[11:0];
      end
   endgenerate

   wire [11:0] per_sel = per_tab[ff_reg*12 +: 12];
   wire [11:0] hi_sel  = hi_tab[ff_reg*12 +: 12];
   wire        tick    = osc_en & (cnt_reg == 12'h000);

   // Command decoder
   always @*
   begin
      ptr_next       = ptr_reg;
      ptr_upper_next = ptr_upper_reg;
      seq_next       = seq_reg;
      wbank_next     = wbank_reg;
      sbank_next     = sbank_reg;
      mux_next       = mux_reg;
      ff_next        = ff_reg;
      disp_next      = disp_reg;
      ram_we         = 1'b0;
      if (cmd_fire)
      begin
         if (register_select == `LCDBP_RS_DATA)
         begin
            ram_we   = 1'b1;
            ptr_next = ptr_reg + 7'h01;
         end
         else if (register_select == `LCDBP_RS_CMD)
         begin
            // Any command other than a pointer step abandons a half-done load
            seq_next = PS_IDLE;
            if (display_byte == `LCDBP_PTR_INIT)
               seq_next = PS_INIT;
            else if (display_byte[7:3] == `LCDBP_PTR_UP_PFX)
            begin
               if (seq_reg == PS_INIT)
               begin
                  ptr_upper_next = display_byte[2:0];           // pointer_upper_bits
                  seq_next       = PS_UPR;
               end
            end
            else if (display_byte[7:4] == `LCDBP_PTR_LO_PFX)
            begin
               if (seq_reg == PS_UPR)
                  ptr_next = {ptr_upper_reg, display_byte[3:0]}; // pointer_lower_bits
            end
            else if (display_byte[7:2] == `LCDBP_WBANK_PFX)
               wbank_next = display_byte[1:0];
            else if (display_byte[7:2] == `LCDBP_SBANK_PFX)
               sbank_next = display_byte[1:0];
            else if (display_byte[7:5] == `LCDBP_FF_PFX)
               ff_next = display_byte[4:0];
            else if (display_byte[7:1] == `LCDBP_DISP_PFX)
               disp_next = display_byte[0];
            else if (display_byte[7:3] == `LCDBP_MUX_PFX)
            begin
               // Codes below 101 are unused and leave the mode alone
               if (display_byte[2:0] >= `LCDBP_MUX_1_4)
                  mux_next = display_byte[2:0];
            end
         end
      end
   end

   // Read data selection
   always @*
   begin
      rd_mux = 32'h0000_0000;
      case (paddr)
         `LCDBP_OFS_CTRL:   rd_mux[1:0] = ctrl_reg;
         `LCDBP_OFS_RDADDR: rd_mux[8:0] = rdaddr_reg;
         `LCDBP_OFS_RDDATA: rd_mux[7:0] = ram_a_q;
         `LCDBP_OFS_STATUS:
         begin
            rd_mux[`LCDBP_ST_PTR_LSB +: 7] = ptr_reg;
            rd_mux[`LCDBP_ST_WB_LSB +: 2]  = wbank_reg;
            rd_mux[`LCDBP_ST_SB_LSB +: 2]  = sbank_reg;
            rd_mux[`LCDBP_ST_MUX_LSB +: 3] = mux_reg;
            rd_mux[`LCDBP_ST_FF_LSB +: 5]  = ff_reg;
            rd_mux[`LCDBP_ST_DISP]         = disp_reg;
            rd_mux[`LCDBP_ST_SEQ_LSB +: 3] = seq_reg;
         end
         default:           rd_mux = 32'h0000_0000;             // CMD and unmapped read zero
      endcase
   end

   // Command state, registers and the APB read path
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ptr_reg       <= `LCDBP_RST_PTR;
         ptr_upper_reg <= 3'b000;
         seq_reg       <= PS_IDLE;
         wbank_reg     <= `LCDBP_RST_BANK;
         sbank_reg     <= `LCDBP_RST_BANK;
         mux_reg       <= `LCDBP_RST_MUX;
         ff_reg        <= `LCDBP_RST_FF;
         disp_reg      <= 1'b0;
         ctrl_reg      <= `LCDBP_RST_CTRL;
         rdaddr_reg    <= 9'h000;
         rd_wait_reg   <= 1'b0;
         prdata        <= 32'h0000_0000;
      end
      else
      begin
         ptr_reg       <= ptr_next;
         ptr_upper_reg <= ptr_upper_next;
         seq_reg       <= seq_next;
         wbank_reg     <= wbank_next;
         sbank_reg     <= sbank_next;
         mux_reg       <= mux_next;
         ff_reg        <= ff_next;
         disp_reg      <= disp_next;
         if (wr_fire && paddr == `LCDBP_OFS_CTRL)
            ctrl_reg <= pwdata[1:0];
         if (wr_fire && paddr == `LCDBP_OFS_RDADDR)
            rdaddr_reg <= pwdata[8:0];
         // First access cycle of a read captures data, the second answers
         if (access && !pwrite && !rd_wait_reg)
         begin
            prdata      <= rd_mux;
            rd_wait_reg <= 1'b1;
         end
         else
            rd_wait_reg <= 1'b0;
      end
   end

   // Internal clock: period and high time follow the frame code
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cnt_reg  <= 12'h000;
         iclk_reg <= 1'b0;
      end
      else if (!osc_en)
      begin
         cnt_reg  <= 12'h000;                                   // Stopped while disabled
         iclk_reg <= 1'b0;
      end
      else
      begin
         // Compare with >= so a shorter period chosen mid-count still wraps
         if (cnt_reg >= per_sel - 12'h001)
            cnt_reg <= 12'h000;
         else
            cnt_reg <= cnt_reg + 12'h001;
         iclk_reg <= (cnt_reg < hi_sel);
      end
   end

   // Frame divider and scan position
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         fr_cnt_reg <= 8'h00;
         phase_reg  <= 2'b00;
         col_reg    <= 7'h00;
         frame_sync <= 1'b0;
      end
      else
      begin
         frame_sync <= 1'b0;
         if (tick)
         begin
            col_reg <= (col_reg == `LCDBP_COLS_LAST) ? 7'h00 : col_reg + 7'h01;
            if (fr_cnt_reg == `LCDBP_FRAME_LAST)
            begin
               fr_cnt_reg <= 8'h00;
               frame_sync <= 1'b1;
               phase_reg  <= phase_reg + 2'b01;
            end
            else
               fr_cnt_reg <= fr_cnt_reg + 8'h01;
         end
      end
   end

   // LCD outputs sit at ground while reset or display disabled
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         backplane_out <= 4'h0;
         segment_out   <= 8'h00;
      end
      else if (!disp_reg)
      begin
         backplane_out <= 4'h0;
         segment_out   <= 8'h00;
      end
      else
      begin
         segment_out <= ram_b_q;
         case (mux_reg)
            `LCDBP_MUX_STATIC: backplane_out <= 4'h1;
            `LCDBP_MUX_1_2:    backplane_out <= phase_reg[0] ? 4'h2 : 4'h1;
            default:           backplane_out <= 4'h1 << phase_reg;
         endcase
      end
   end

   assign clk_out    = iclk_reg & coe;
   assign clk_out_oe = coe;
   assign display_on = disp_reg;

   // Display RAM
   lcdbp_ram u_ram (
      .clk       (pclk),
      .wr_en     (ram_we),
      .wr_addr   ({row_of(wbank_reg, mux_reg, 2'b00), ptr_reg}),
      .wr_data   (display_byte),
      .rd_a_addr (rdaddr_reg),
      .rd_a_data (ram_a_q),
      .rd_b_addr ({row_of(sbank_reg, mux_reg, phase_reg), col_reg}),
      .rd_b_data (ram_b_q)
   );
endmodule // lcdbp_ctrl

// ---- bench/lcdbp_checker.sv ----
// Concurrent checks on the ports of the LCD bank and pointer command block.
// Assumes one pclk domain and an APB master that holds each request until pready.
`timescale 1ns/1ns
module lcdbp_checker (
   // Clock and reset
   input wire        pclk,
   input wire        presetn,
   // APB
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [7:0]  paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire        pready,
   input wire        pslverr,
   // Pins
   input wire        clk_out,
   input wire        clk_out_oe,
   input wire [3:0]  backplane_out,
   input wire [7:0]  segment_out,
   input wire        frame_sync,
   input wire        display_on
);
   // Access phase, unmapped address and the two write kinds that may move pins
   wire acc = psel && penable;
   wire bad = (paddr > 8'h10) || (paddr[1:0] != 2'h0);
   wire cmdw = acc && pwrite && (paddr == 8'h00);
   wire ctrlw = acc && pwrite && (paddr == 8'h04);
   wire oe_bit = pwdata[1];

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   chk_wr_nowait: assert property (acc && pwrite |-> pready)
      else $error("write access waited");
   chk_rd_onewait: assert property (acc && !pwrite && $rose(penable) |-> !pready ##1 (acc && pready))
      else $error("read did not take exactly one wait state");
   chk_err_idle: assert property (!acc |-> !pslverr)
      else $error("error flag outside an access");
   chk_err_map: assert property (acc && pready |-> pslverr == bad)
      else $error("error flag does not match address decode");
   chk_rdata_hold: assert property (!(acc && !pwrite) |=> $stable(prdata))
      else $error("read data moved outside a read");
   chk_dark_pins: assert property (!display_on && !$past(display_on) |-> backplane_out == 4'h0 && segment_out == 8'h00)
      else $error("drive pins active while display off");
   chk_clk_gate: assert property (!clk_out_oe |-> !clk_out)
      else $error("clock pin toggles while not enabled");
   chk_oe_load: assert property (ctrlw ##1 1'b1 |-> clk_out_oe == $past(oe_bit))
      else $error("clock out enable not loaded from write");
   chk_disp_hold: assert property (!cmdw && !$past(cmdw) |=> $stable(display_on))
      else $error("display enable moved without a command");
   chk_sync_pulse: assert property (frame_sync |=> !frame_sync)
      else $error("frame pulse longer than one cycle");
endmodule // lcdbp_checker

bind lcdbp_ctrl lcdbp_checker lcdbp_checker_i (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .clk_out(clk_out), .clk_out_oe(clk_out_oe),
   .backplane_out(backplane_out), .segment_out(segment_out), .frame_sync(frame_sync),
   .display_on(display_on));

// ---- bench/lcdbp_host.sv ----
// Host model: an APB master that issues one transfer at a time.
// Assumes each transfer is started just after a rising pclk edge.
`timescale 1ns/1ns
module lcdbp_host (
   // Clock
   input  wire        pclk,
   // APB request
   output reg         psel,
   output reg         penable,
   output reg         pwrite,
   output reg  [7:0]  paddr,
   output reg  [31:0] pwdata,
   // APB answer
   input  wire [31:0] prdata,
   input  wire        pready,
   input  wire        pslverr
);
   // Idle bus from time zero
   initial
   begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
   end

   // One transfer. The answer is read right after each rising edge, before that edge's
   // updates land, so it is exactly what the design sampled there.
   task xfer(input w, input [7:0] a, input [31:0] d, output [31:0] r, output e, output k);
      integer n;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 1'b0;
      n = 0;
      // Bounded wait for pready
      while (!k && n < 20)
      begin
         @(posedge pclk);
         k = (pready === 1'b1);
         r = prdata;
         e = pslverr;
         n = n + 1;
      end
      // Release; stale address and data are inverted so nothing can lean on them
      psel <= 1'b0;
      penable <= 1'b0;
      paddr <= ~a;
      pwdata <= ~d;
      @(posedge pclk);
   endtask
endmodule // lcdbp_host

// ---- bench/lcdbp_ctrl_tb.sv ----
// Self-checking bench for the LCD bank and pointer command block.
// Assumes the host model drives APB and the checker is bound to the design.
`timescale 1ns/1ns
module lcdbp_ctrl_tb;
   // Clock, reset, APB and pins
   reg         pclk = 1'b0;
   reg         presetn = 1'b0;
   wire        psel, penable, pwrite, pready, pslverr;
   wire [7:0]  paddr;
   wire [31:0] pwdata, prdata;
   wire        clk_out, clk_out_oe, frame_sync, display_on;
   wire [3:0]  backplane_out;
   wire [7:0]  segment_out;
   // Counters, seed, last answer
   integer     err_total = 0;
   integer     compares = 0;
   integer     i, j, k, h, l;
   reg  [31:0] rnd = 32'hEE66863D;
   reg  [31:0] rd;
   reg         ok, er;
   // Expected block state, kept by the bench
   reg  [6:0]  ptr = 7'h00;
   reg  [2:0]  pu = 3'h0, mux = 3'h5, seq = 3'h1;
   reg  [4:0]  ff = 5'h07;
   reg  [1:0]  wb = 2'h0, sb = 2'h0;
   reg         de = 1'b0;
   reg  [7:0]  mem [0:511];

   always #25 pclk = ~pclk;

   lcdbp_ctrl lcdbp_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .clk_out(clk_out), .clk_out_oe(clk_out_oe), .backplane_out(backplane_out),
      .segment_out(segment_out), .frame_sync(frame_sync), .display_on(display_on));
   lcdbp_host lcdbp_host_i (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

   // Next pseudo-random word
   function [31:0] lfsr(input [31:0] s);
      lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // STATUS word the block should show
   function [31:0] stat();
      stat = {8'h00, seq, de, ff, mux, sb, wb, 1'b0, ptr};
   endfunction
   // RAM row that a bank code writes in the current mode; 1:4 ignores the code
   function [1:0] row(input [1:0] c);
      row = (mux == 3'h7) ? c : (mux == 3'h6) ? {c[1], 1'b0} : 2'h0;
   endfunction

   // Compare and count
   task chk(input string nm, input [31:0] seen, input [31:0] exp);
      compares = compares + 1;
      if (seen !== exp)
      begin
         err_total = err_total + 1;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // One APB transfer; a missing pready counts as a mismatch
   task bus(input w, input [7:0] a, input [31:0] d);
      lcdbp_host_i.xfer(w, a, d, rd, er, ok);
      chk("pready", {31'h0, ok}, 32'h1);
   endtask
   // Issue one command and update the expected state
   task cmd(input [1:0] rs, input [7:0] b);
      bus(1'b1, 8'h00, {22'h0, rs, b});
      if (rs == 2'h1)
      begin
         mem[{row(wb), ptr}] = b;
         ptr = ptr + 7'h1;
      end
      else if (rs == 2'h0)
      begin
         if (b[7:3] == 5'h00 && b[2:0] >= 3'h5) mux = b[2:0];
         if (b[7:1] == 7'h1C) de = b[0];
         if (b[7:5] == 3'h7) ff = b[4:0];
         if (b[7:2] == 6'h02) wb = b[1:0];
         if (b[7:2] == 6'h04) sb = b[1:0];
         if (b[7:3] == 5'h10 && seq == 3'h2) pu = b[2:0];
         if (b[7:4] == 4'h9 && seq == 3'h4) ptr = {pu, b[3:0]};
         seq = (b == 8'hA0) ? 3'h2 : (b[7:3] == 5'h10 && seq == 3'h2) ? 3'h4 : 3'h1;
      end
   endtask
   // Read STATUS and compare with the bench state
   task cstat;
      bus(1'b0, 8'h08, 32'h0);
      chk("status", rd, stat());
   endtask
   // Pointer load in the only legal order
   task setp(input [6:0] p);
      cmd(2'h0, 8'hA0);
      cmd(2'h0, {5'h10, p[6:4]});
      cmd(2'h0, {4'h9, p[3:0]});
   endtask
   // Read one RAM byte back through the debug window
   task peek(input [8:0] a);
      bus(1'b1, 8'h0C, {23'h0, a});
      bus(1'b0, 8'h10, 32'h0);
      chk("ram", rd, {24'h0, mem[a]});
   endtask
   // Count falling edges until the clock pin shows v
   task upto(input v, output integer n);
      n = 0;
      while (clk_out !== v && n < 4000)
      begin
         @(negedge pclk);
         n = n + 1;
      end
   endtask
   // Select a frame code, skip a settling period, then time one high and one low phase
   task clk_meas(input [4:0] c, input integer hz, input integer duty);
      integer per;
      per = 20000000 / hz;
      cmd(2'h0, {3'h7, c});
      for (j = 0; j < 4; j = j + 1) upto(~j[0], h);
      upto(1'b1, l);
      chk("high", h, per * duty / 100);
      chk("period", h + l, per);
      @(posedge pclk);
   endtask

   // Verdict, used by the main sequence and the watchdog
   task give_verdict;
      $display("compares %0d errors %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // Main sequence
   initial
   begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      repeat (20000) @(posedge pclk);
      chk("pins", {17'h0, display_on, backplane_out, segment_out, clk_out_oe, frame_sync}, 32'h0);
      cstat;
      bus(1'b0, 8'h04, 32'h0);
      chk("ctrl", rd, 32'h0);
      bus(1'b0, 8'h20, 32'h0);
      chk("slverr", {31'h0, er}, 32'h1);
      bus(1'b1, 8'h08, 32'hFFFFFFFF);
      // Pointer fragments out of order must not move the pointer
      // No initialise command exists here, so configuration starts at once
      cmd(2'h0, 8'h83);
      cmd(2'h0, 8'h95);
      cstat;
      // Every multiplex code, unused ones too
      for (i = 0; i < 8; i = i + 1)
      begin
         cmd(2'h0, i[7:0]);
         cstat;
      end
      // Random frame codes
      for (i = 0; i < 6; i = i + 1)
      begin
         rnd = lfsr(rnd);
         cmd(2'h0, {3'h7, rnd[4:0]});
         cstat;
      end
      // Clear all four rows in static mode before use
      cmd(2'h0, 8'h07);
      for (i = 0; i < 4; i = i + 1)
      begin
         cmd(2'h0, {6'h02, i[1:0]});
         setp(7'h00);
         for (j = 0; j < 128; j = j + 1) cmd(2'h1, 8'h00);
      end
      // Static, 1:2, 1:4: random banks, pointer wrap in the first pass
      for (i = 0; i < 3; i = i + 1)
      begin
         rnd = lfsr(rnd);
         cmd(2'h0, {5'h00, 3'h7 - i[2:0]});
         cmd(2'h0, {6'h02, rnd[1:0]});
         cmd(2'h0, {6'h04, rnd[3:2]});
         setp(i == 0 ? 7'h7E : rnd[10:4]);
         for (j = 0; j < 3; j = j + 1) cmd(2'h1, rnd[31:24] ^ j[7:0]);
         cmd(2'h2, rnd[23:16]);
         cstat;
         for (j = 0; j < 3; j = j + 1)
            for (k = 0; k < 4; k = k + 1) peek({k[1:0], ptr - 7'h3 + j[6:0]});
      end
      // Display on, clock out on, then time the internal clock
      cmd(2'h0, 8'h39);
      cstat;
      // Oscillator still off: 1:4 scan rests on backplane 0, column 0 of row 0
      chk("backplane", {28'h0, backplane_out}, 32'h1);
      chk("segment", {24'h0, segment_out}, {24'h0, mem[9'h000]});
      bus(1'b1, 8'h04, 32'h3);
      bus(1'b0, 8'h04, 32'h0);
      chk("ctrl", rd, 32'h3);
      clk_meas(5'h1F, 42667, 41);
      clk_meas(5'h1A, 36000, 50);
      clk_meas(5'h00, 6472, 29);
      give_verdict;
   end

   // Watchdog, well past the expected run length
   initial
   begin
      repeat (60000) @(posedge pclk);
      err_total = err_total + 1;
      give_verdict;
   end
endmodule // lcdbp_ctrl_tb
